// file: bench/ascs_assertions.sv
// Checker: bus handshakes, reset levels and error interrupt of the serial port
`timescale 1ns/1ps
module ascs_assertions
	import ascs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// Read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	// Pins
	input wire logic txd_out,
	input wire logic txd_oe_n,
	input wire logic rx_error_irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_irq_off;
		s_wr_taken ##0 (s_axi_awaddr == ADDR_CONTROL_THREE && s_axi_wstrb[0]
			&& s_axi_wdata[3:0] == 4'h0);
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid && !s_axi_awready
		##1 s_axi_bvalid && !s_axi_awready)
		else $error("write response missing");
	a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing");
	a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during data");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_unmapped_err: assert property (s_rd_taken ##0 (s_axi_araddr == 8'h20)
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_reset_idle: assert property ($fell(reset) |-> txd_out && !txd_oe_n && !rx_error_irq)
		else $error("pins not idle after reset");
	a_irq_masked: assert property (s_irq_off |-> ##3 !rx_error_irq)
		else $error("interrupt with enables clear");
endmodule
bind ascs_top ascs_assertions chk (.*);

// file: bench/ascs_remote.sv
// Remote serial device: sends frames on the receive line and decodes the transmit line
`timescale 1ns/1ps
module ascs_remote
#(
	parameter int BIT_CYC = 32
)
(
	// Clock
	input wire logic sys_clk,
	// Serial lines
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	// Start bit, data LSB first, stop bit, then driven back high
	task automatic send(input int nb, input logic [8:0] v, input logic stp);
		@(posedge sys_clk);
		line_out <= 1'b0;
		repeat (BIT_CYC) @(posedge sys_clk);
		for (int i = 0; i < nb; i++)
		begin
			line_out <= v[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
		line_out <= stp;
		repeat (BIT_CYC) @(posedge sys_clk);
		line_out <= 1'b1;
	endtask
	// Samples each data bit in its middle
	task automatic catch(input int nb, output logic [8:0] v);
		v = 9'h000;
		@(negedge line_in);
		repeat (BIT_CYC + BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < nb; i++)
		begin
			v[i] = line_in;
			repeat (BIT_CYC) @(posedge sys_clk);
		end
	endtask
	// Length of the first low run longer than three bits
	task automatic low_run(output int n);
		n = 0;
		while (n <= 3 * BIT_CYC)
		begin
			@(negedge line_in);
			n = 0;
			while (line_in !== 1'b1)
			begin
				@(posedge sys_clk);
				n++;
			end
		end
	endtask
endmodule

// file: bench/test_async_serial_ctrl_status.sv
// Testbench: registers, transmit, receive, nine-bit, error interrupt and single-wire
`timescale 1ns/1ps
module test_async_serial_ctrl_status;
	import ascs_pkg::*;
	localparam int BIT = 32;
	localparam logic [7:0] S1 = ADDR_STATUS_ONE;
	localparam logic [7:0] S2 = ADDR_STATUS_TWO;
	localparam logic [7:0] C3 = ADDR_CONTROL_THREE;
	localparam logic [7:0] DP = ADDR_SERIAL_DATA_PORT;
	localparam logic [7:0] CM = ADDR_CONTROL_MAIN;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic txd_out, txd_oe_n, rx_error_irq, rxd_in;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [1:0] bresp_seen = 2'h0;
	wire txd_in = txd_oe_n ? 1'b1 : txd_out;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	ascs_top uut (.*);
	ascs_remote #(.BIT_CYC(BIT)) far (.sys_clk(sys_clk), .line_in(txd_out), .line_out(rxd_in));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
			begin
				bresp_seen = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(nm, d & m, e);
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rchk(S2, 32'hFFFFFFFF, 32'h0, "status_two");
		rchk(C3, 32'hFFFFFFFF, 32'h0, "control_three");
		axw(S2, 8'hFF);
		chk("write okay", {30'h0, bresp_seen}, {30'h0, RESP_OKAY});
		rchk(S2, 32'hFF, 32'h04, "status_two write");
		axw(S2, 8'h00);
		axr(8'h20, d, r);
		chk("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
		axw(8'h20, 8'h00);
		chk("write refused", {30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
		$display("regs test done");
	endtask
	task automatic t_tx;
		logic [8:0] v;
		int n;
		fork
			far.catch(8, v);
			axw(DP, 8'hA5);
		join
		chk("tx byte", {23'h0, v}, 32'hA5);
		axw(S2, 8'h04);
		fork
			far.low_run(n);
			begin
				axw(DP, 8'hFF);
				axw(CM, 8'h0E);
				axw(CM, 8'h06);
			end
		join
		chk("break bits", (n + BIT / 2) / BIT, 32'hD);
		axw(S2, 8'h00);
		repeat (2 * BIT) @(posedge sys_clk);
		axw(C3, 8'h10);
		repeat (3) @(posedge sys_clk);
		chk("inverted idle", {31'h0, txd_out}, 32'h0);
		axw(C3, 8'h00);
		$display("tx test done");
	endtask
	task automatic t_rx;
		fork
			far.send(8, 9'h03C, 1'b1);
			begin
				repeat (3 * BIT) @(posedge sys_clk);
				rchk(S2, 32'h1, 32'h1, "rx active");
			end
		join
		rchk(S1, 32'h20, 32'h20, "full set");
		rchk(DP, 32'hFF, 32'h3C, "rx byte");
		rchk(S1, 32'h20, 32'h0, "full clear");
		repeat (12 * BIT) @(posedge sys_clk);
		rchk(S2, 32'h1, 32'h0, "rx idle");
		$display("rx test done");
	endtask
	task automatic t_nine;
		logic [8:0] v;
		axw(CM, 8'h07);
		axw(C3, 8'h40);
		fork
			far.catch(9, v);
			axw(DP, 8'h55);
		join
		chk("tx nine", {23'h0, v}, 32'h155);
		far.send(9, 9'h1AA, 1'b1);
		rchk(S1, 32'h20, 32'h20, "full nine");
		rchk(DP, 32'hFF, 32'hAA, "rx nine");
		rchk(S1, 32'h20, 32'h20, "full held");
		rchk(C3, 32'hFF, 32'hC0, "ninth bits");
		rchk(S1, 32'h20, 32'h0, "full clear nine");
		axw(CM, 8'h06);
		axw(C3, 8'h00);
		$display("nine-bit test done");
	endtask
	task automatic t_err;
		logic [31:0] d;
		logic [1:0] r;
		axw(S2, 8'h04);
		far.send(8, 9'h055, 1'b0);
		rchk(S1, 32'h02, 32'h02, "framing flag");
		chk("irq polled", {31'h0, rx_error_irq}, 32'h0);
		axw(C3, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk("irq framing", {31'h0, rx_error_irq}, 32'h1);
		axw(C3, 8'h0D);
		repeat (2) @(posedge sys_clk);
		chk("irq others", {31'h0, rx_error_irq}, 32'h0);
		far.send(8, 9'h0F0, 1'b1);
		repeat (2) @(posedge sys_clk);
		chk("irq overrun", {31'h0, rx_error_irq}, 32'h1);
		rchk(S1, 32'h08, 32'h08, "overrun flag");
		axw(C3, 8'h00);
		axw(S2, 8'h00);
		axr(DP, d, r);
		rchk(S1, 32'h0A, 32'h0, "framing clear");
		$display("error test done");
	endtask
	task automatic t_wire;
		axw(CM, 8'h36);
		repeat (2) @(posedge sys_clk);
		chk("pin input", {31'h0, txd_oe_n}, 32'h1);
		axw(C3, 8'h20);
		repeat (2) @(posedge sys_clk);
		chk("pin output", {31'h0, txd_oe_n}, 32'h0);
		axw(C3, 8'h00);
		axw(CM, 8'h06);
		$display("single-wire test done");
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			failures++;
			complete_run;
		end
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		t_regs;
		axw(ADDR_BAUD_DIV, 8'h02);
		axw(CM, 8'h06);
		repeat (12 * BIT) @(posedge sys_clk);
		t_tx;
		t_rx;
		t_nine;
		t_err;
		t_wire;
		complete_run;
	end
endmodule

// file: rtl/ascs_pkg.sv
// Package: register map, field positions, reset values and timing counts for the serial port
package ascs_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h04;
	localparam logic [7:0] ADDR_SERIAL_DATA_PORT = 8'h08;
	localparam logic [7:0] ADDR_BAUD_DIV = 8'h0C;
	localparam logic [7:0] ADDR_CONTROL_MAIN = 8'h10;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h14;
	// status_two fields
	localparam int STS2_RAF_BIT = 0;
	localparam int STS2_LONG_BREAK_BIT = 2;
	// control_three fields
	localparam int C3_RX8_BIT = 7;
	localparam int C3_TX8_BIT = 6;
	localparam int C3_SINGLE_WIRE_OUTPUT_SEL_BIT = 5;
	localparam int C3_TX_POLARITY_FLIP_BIT = 4;
	localparam int C3_OVERRUN_IRQ_EN_BIT = 3;
	localparam int C3_NOISE_IRQ_EN_BIT = 2;
	localparam int C3_FRAMING_IRQ_EN_BIT = 1;
	localparam int C3_PARITY_IRQ_EN_BIT = 0;
	// control_main fields
	localparam int CM_NINE_BIT = 0;
	localparam int CM_TX_EN_BIT = 1;
	localparam int CM_RX_EN_BIT = 2;
	localparam int CM_SEND_BREAK_BIT = 3;
	localparam int CM_LOOP_BIT = 4;
	localparam int CM_RECEIVER_SOURCE_SEL_BIT = 5;
	// status_one fields
	localparam int S1_PF_BIT = 0;
	localparam int S1_FE_BIT = 1;
	localparam int S1_NF_BIT = 2;
	localparam int S1_OR_BIT = 3;
	localparam int S1_IDLE_BIT = 4;
	localparam int S1_RX_BUFFER_FULL_FLAG_BIT = 5;
	localparam int S1_TC_BIT = 6;
	localparam int S1_TDRE_BIT = 7;
	// Reset values
	localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
	localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;
	localparam logic [12:0] BAUD_DIV_RESET = 13'h0004;
	// Frame and break lengths in bit times, and the last tick count (15) of the 16 ticks in a bit
	localparam logic [3:0] FRAME_BITS_8 = 4'hA;
	localparam logic [3:0] FRAME_BITS_9 = 4'hB;
	localparam logic [3:0] BREAK_SHORT = 4'hA;
	localparam logic [3:0] BREAK_LONG = 4'hD;
	localparam logic [3:0] OVERSAMPLE = 4'hF;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/ascs_top.sv
// Serial port: control_three/status_two/data registers, baud generator, tx and rx
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ascs_top
	import ascs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial pins
	input wire logic rxd_in,
	input wire logic txd_in,
	output logic txd_out,
	output logic txd_oe_n,
	// Interrupt
	output logic rx_error_irq
);
	import ascs_pkg::*;

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// Registers
	logic long_break_select_reg;
	logic [5:0] c3_ctrl_reg;
	logic tx_ninth_bit_reg;
	logic rx_ninth_bit_reg;
	logic [12:0] baud_div_reg;
	logic [5:0] ctrl_main_reg;
	logic [7:0] rx_data_reg;
	logic [8:0] tx_buf_reg;
	logic tx_buf_full_reg;
	logic rx_buffer_full_flag_reg, or_reg, nf_reg, fe_reg, pf_reg, idle_reg, tc_reg;
	logic rx_active_flag_reg;
	logic s1_seen_reg, d_read_reg, c3_read_reg;
	logic aw_got_reg, w_got_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic w_strb0_reg;

	wire nine_bit = ctrl_main_reg[CM_NINE_BIT];
	wire single_wire = ctrl_main_reg[CM_LOOP_BIT] & ctrl_main_reg[CM_RECEIVER_SOURCE_SEL_BIT];
	wire loop_int = ctrl_main_reg[CM_LOOP_BIT] & ~ctrl_main_reg[CM_RECEIVER_SOURCE_SEL_BIT];

	// AXI write channel
	wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	wire rd_fire = s_axi_arvalid & s_axi_arready;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb0_reg <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb0_reg <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= ADDR_STATUS_ONE)
					? RESP_OKAY : RESP_SLVERR;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	wire wr_en = wr_fire & w_strb0_reg;
	wire wr_data = wr_en && aw_addr_reg == ADDR_SERIAL_DATA_PORT;

	// AXI read channel
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_STATUS_TWO: s_axi_rdata <= {29'h0, long_break_select_reg, 1'b0,
					rx_active_flag_reg};
				ADDR_CONTROL_THREE: s_axi_rdata <= {24'h0, rx_ninth_bit_reg, tx_ninth_bit_reg,
					c3_ctrl_reg};
				ADDR_SERIAL_DATA_PORT: s_axi_rdata <= {24'h0, rx_data_reg};
				ADDR_BAUD_DIV: s_axi_rdata <= {19'h0, baud_div_reg};
				ADDR_CONTROL_MAIN: s_axi_rdata <= {26'h0, ctrl_main_reg};
				ADDR_STATUS_ONE: s_axi_rdata <= {24'h0, ~tx_buf_full_reg, tc_reg, rx_buffer_full_flag_reg,
					idle_reg, or_reg, nf_reg, fe_reg, pf_reg};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid & s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	wire rd_s1 = rd_fire && s_axi_araddr == ADDR_STATUS_ONE;
	wire rd_data = rd_fire && s_axi_araddr == ADDR_SERIAL_DATA_PORT;
	wire rd_c3 = rd_fire && s_axi_araddr == ADDR_CONTROL_THREE;

	// Control registers; receiver-active bit is not writable
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			long_break_select_reg <= STATUS_TWO_RESET[STS2_LONG_BREAK_BIT];
			c3_ctrl_reg <= CONTROL_THREE_RESET[5:0];
			tx_ninth_bit_reg <= CONTROL_THREE_RESET[C3_TX8_BIT];
			baud_div_reg <= BAUD_DIV_RESET;
			ctrl_main_reg <= 6'h00;
		end
		else if (wr_en)
		begin
			unique case (aw_addr_reg)
				ADDR_STATUS_TWO: long_break_select_reg <= w_data_reg[STS2_LONG_BREAK_BIT];
				ADDR_CONTROL_THREE:
				begin
					c3_ctrl_reg <= w_data_reg[5:0];
					tx_ninth_bit_reg <= w_data_reg[C3_TX8_BIT];
				end
				ADDR_BAUD_DIV: baud_div_reg <= w_data_reg[12:0];
				ADDR_CONTROL_MAIN: ctrl_main_reg <= w_data_reg[5:0];
				default: ;
			endcase
		end
	end

	// Baud generator: 16x tick from bus clock modulo divider
	logic [12:0] baud_cnt_reg;
	logic tick_reg;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			baud_cnt_reg <= 13'h0000;
			tick_reg <= 1'b0;
		end
		else if (baud_cnt_reg + 13'h0001 >= baud_div_reg)
		begin
			baud_cnt_reg <= 13'h0000;
			tick_reg <= baud_div_reg != 13'h0000;
		end
		else
		begin
			baud_cnt_reg <= baud_cnt_reg + 13'h0001;
			tick_reg <= 1'b0;
		end
	end

	// Transmitter
	logic [10:0] tx_shift_reg;
	logic [3:0] tx_bits_reg;
	logic [3:0] tx_rt_reg;
	logic tx_busy_reg, tx_line_reg;
	logic tx_brk_reg, tx_brk_pend_reg;
	wire [3:0] frame_len = nine_bit ? FRAME_BITS_9 : FRAME_BITS_8;
	wire [3:0] break_len = (long_break_select_reg ? BREAK_LONG : BREAK_SHORT)
		+ {3'h0, nine_bit};
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			tx_buf_reg <= 9'h000;
			tx_buf_full_reg <= 1'b0;
			tx_busy_reg <= 1'b0;
			tx_shift_reg <= 11'h7FF;
			tx_bits_reg <= 4'h0;
			tx_rt_reg <= 4'h0;
			tx_line_reg <= 1'b1;
			tc_reg <= 1'b1;
			tx_brk_reg <= 1'b0;
			tx_brk_pend_reg <= 1'b0;
		end
		else
		begin
			if (wr_data)
			begin
				tx_buf_reg <= {tx_ninth_bit_reg, w_data_reg[7:0]};
				tx_buf_full_reg <= 1'b1;
				tc_reg <= 1'b0;
			end
			if (tick_reg)
			begin
				if (tx_busy_reg)
				begin
					tx_rt_reg <= tx_rt_reg + 4'h1;
					if (tx_rt_reg == OVERSAMPLE)
					begin
						tx_line_reg <= tx_shift_reg[0];
						tx_shift_reg <= {~tx_brk_reg, tx_shift_reg[10:1]};
						tx_bits_reg <= tx_bits_reg - 4'h1;
						if (tx_bits_reg == 4'h0)
						begin
							tx_busy_reg <= 1'b0;
							tx_line_reg <= 1'b1;
							tc_reg <= ~tx_buf_full_reg;
						end
					end
				end
				else if (ctrl_main_reg[CM_TX_EN_BIT] & tx_brk_pend_reg)
				begin
					tx_shift_reg <= 11'h000;
					tx_brk_reg <= 1'b1;
					tx_brk_pend_reg <= 1'b0;
					tx_bits_reg <= break_len;
					tx_busy_reg <= 1'b1;
					tx_rt_reg <= 4'h0;
				end
				else if (ctrl_main_reg[CM_TX_EN_BIT] & tx_buf_full_reg & ~wr_data)
				begin
					tx_shift_reg <= nine_bit ? {1'b1, tx_buf_reg, 1'b0}
						: {2'b11, tx_buf_reg[7:0], 1'b0};
					tx_bits_reg <= frame_len;
					tx_brk_reg <= 1'b0;
					tx_busy_reg <= 1'b1;
					tx_buf_full_reg <= 1'b0;
					tx_rt_reg <= 4'h0;
				end
			end
			// Break is queued while the send bit is set, even if the shifter is busy
			if (ctrl_main_reg[CM_SEND_BREAK_BIT])
				tx_brk_pend_reg <= 1'b1;
		end
	end
	// Pin drive and direction
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			txd_out <= 1'b1;
			txd_oe_n <= 1'b0;
		end
		else
		begin
			txd_out <= tx_line_reg ^ c3_ctrl_reg[C3_TX_POLARITY_FLIP_BIT];
			txd_oe_n <= single_wire & ~c3_ctrl_reg[C3_SINGLE_WIRE_OUTPUT_SEL_BIT];
		end
	end

	// Receiver
	typedef enum {RX_IDLE, RX_START, RX_DATA} ascs_rx_state_t;
	ascs_rx_state_t rx_state_reg;
	logic [2:0] rx_hist_reg;
	logic [3:0] rx_rt_reg, rx_bit_reg, rx_idle_cnt_reg;
	logic [2:0] rx_smp_reg;
	logic [9:0] rx_shift_reg;
	logic rx_noise_reg, rx_prev_reg;
	wire rx_line = single_wire ? txd_in : (loop_int ? tx_line_reg : rxd_in);
	wire rx_fall = rx_prev_reg & ~rx_line;
	wire rx_bit_val = majority(rx_smp_reg);
	wire rx_done = rx_state_reg == RX_DATA && tick_reg && rx_rt_reg == 4'hA
		&& rx_bit_reg == frame_len - 4'h1;
	wire [9:0] rx_final = {majority({rx_smp_reg[1:0], rx_line}), rx_shift_reg[9:1]};
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rx_state_reg <= RX_IDLE;
			rx_hist_reg <= 3'h0;
			rx_rt_reg <= 4'h0;
			rx_bit_reg <= 4'h0;
			rx_smp_reg <= 3'h0;
			rx_shift_reg <= 10'h000;
			rx_noise_reg <= 1'b0;
			rx_prev_reg <= 1'b1;
			rx_active_flag_reg <= 1'b0;
			rx_idle_cnt_reg <= 4'h0;
		end
		else if (tick_reg & ctrl_main_reg[CM_RX_EN_BIT])
		begin
			rx_prev_reg <= rx_line;
			rx_rt_reg <= rx_rt_reg + 4'h1;
			rx_smp_reg <= {rx_smp_reg[1:0], rx_line};
			unique case (rx_state_reg)
				RX_IDLE:
				begin
					rx_hist_reg <= {rx_hist_reg[1:0], rx_line};
					if (rx_hist_reg == 3'h7 && !rx_line)
					begin
						rx_state_reg <= RX_START;
						rx_rt_reg <= 4'h2;
						rx_noise_reg <= 1'b0;
					end
					if (rx_line && rx_idle_cnt_reg != frame_len)
						rx_idle_cnt_reg <= rx_idle_cnt_reg + {3'h0, rx_rt_reg == OVERSAMPLE};
					if (rx_line && rx_idle_cnt_reg == frame_len)
						rx_active_flag_reg <= 1'b0;
				end
				RX_START:
					if (rx_rt_reg == 4'h7)
					begin
						if (!majority({rx_smp_reg[1], rx_smp_reg[0] & rx_line, rx_line}))
						begin
							rx_state_reg <= RX_DATA;
							rx_bit_reg <= 4'h0;
							rx_active_flag_reg <= 1'b1;
						end
						else
						begin
							rx_state_reg <= RX_IDLE;
							rx_hist_reg <= 3'h0;
						end
					end
				RX_DATA:
				begin
					if (rx_fall)
						rx_rt_reg <= 4'h2;
					if (rx_rt_reg == 4'hA)
					begin
						rx_shift_reg <= {majority({rx_smp_reg[1:0], rx_line}), rx_shift_reg[9:1]};
						if (rx_smp_reg[1:0] != {2{rx_line}})
							rx_noise_reg <= 1'b1;
						rx_bit_reg <= rx_bit_reg + 4'h1;
						if (rx_done)
						begin
							rx_state_reg <= RX_IDLE;
							rx_hist_reg <= 3'h0;
							rx_idle_cnt_reg <= 4'h0;
						end
					end
				end
			endcase
		end
	end

	// Receive buffer and flags
	wire s1_seen = s1_seen_reg | rd_s1;
	wire clr_seq = s1_seen & (d_read_reg | rd_data) & (~nine_bit | c3_read_reg | rd_c3);
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rx_data_reg <= 8'h00;
			rx_ninth_bit_reg <= 1'b0;
			{rx_buffer_full_flag_reg, or_reg, nf_reg, fe_reg, pf_reg, idle_reg} <= 6'h00;
			{s1_seen_reg, d_read_reg, c3_read_reg} <= 3'h0;
		end
		else
		begin
			if (rd_s1 && (rx_buffer_full_flag_reg | or_reg | fe_reg))
				s1_seen_reg <= 1'b1;
			if (rd_data & s1_seen)
				d_read_reg <= 1'b1;
			if (rd_c3 & s1_seen)
				c3_read_reg <= 1'b1;
			if (clr_seq & (rd_data | rd_c3))
			begin
				{rx_buffer_full_flag_reg, or_reg, nf_reg, fe_reg, pf_reg, idle_reg} <= 6'h00;
				{s1_seen_reg, d_read_reg, c3_read_reg} <= 3'h0;
			end
			if (rx_done & tick_reg & ctrl_main_reg[CM_RX_EN_BIT])
			begin
				if (rx_buffer_full_flag_reg || fe_reg)
					or_reg <= 1'b1;
				else
				begin
					rx_data_reg <= nine_bit ? rx_final[7:0] : rx_final[8:1];
					rx_ninth_bit_reg <= nine_bit ? rx_final[8] : 1'b0;
					rx_buffer_full_flag_reg <= 1'b1;
					nf_reg <= rx_noise_reg;
					fe_reg <= ~rx_final[9];
				end
			end
		end
	end

	// Combined error interrupt
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			rx_error_irq <= 1'b0;
		else
			rx_error_irq <= (or_reg & c3_ctrl_reg[C3_OVERRUN_IRQ_EN_BIT])
				| (nf_reg & c3_ctrl_reg[C3_NOISE_IRQ_EN_BIT])
				| (fe_reg & c3_ctrl_reg[C3_FRAMING_IRQ_EN_BIT])
				| (pf_reg & c3_ctrl_reg[C3_PARITY_IRQ_EN_BIT]);
	end
endmodule
